// File: inc/smp_defs.svh
// Register map, field positions, reset values and timing counts of the
// multiprocessor serial unit.
// Assumes a 12-bit APB byte address and 32-bit data.
`ifndef SMP_DEFS_SVH
`define SMP_DEFS_SVH

// Register byte offsets
`define SMP_OFF_CTRL    12'h000
`define SMP_OFF_BAUD    12'h004
`define SMP_OFF_TXBUF   12'h008
`define SMP_OFF_RXBUF   12'h00C
`define SMP_OFF_STATUS  12'h010

// Control register fields
`define SMP_CTRL_W      11
`define SMP_CTRL_RST    11'h000
`define SMP_CTRL_MODE   2:0
`define SMP_CTRL_FILT   3
`define SMP_CTRL_POL    4
`define SMP_CTRL_TXEN   5
`define SMP_CTRL_RXEN   6
`define SMP_CTRL_EXTCK  7
`define SMP_CTRL_RTSEN  8
`define SMP_CTRL_STP2   9
`define SMP_CTRL_MP_RECEIVE_ENABLE   10

// Serial mode field encodings
`define SMP_MODE_SYNC   3'h1
`define SMP_MODE_MP7    3'h4
`define SMP_MODE_MP8    3'h5

// Buffer and status fields
`define SMP_BUF_MP      8
`define SMP_RX_OVR      12
`define SMP_RX_FER      13
`define SMP_RX_SUM      15
`define SMP_ST_TXEMPTY  0
`define SMP_ST_TXIDLE   1
`define SMP_ST_RXFULL   2
`define SMP_ST_OVR      3
`define SMP_ST_FER      4
`define SMP_ST_SUM      5

// Timing: sixteen ticks per bit, half a shift clock is eight ticks
`define SMP_BAUD_RST    16'h0040
`define SMP_TICK_LAST   4'hF
`define SMP_TICK_MID    4'h7
`define SMP_HALF_LAST   3'h7
`define SMP_SYNC_LAST   4'h7
`define SMP_LEFT_MP8    4'h9
`define SMP_LEFT_MP7    4'h8
`define SMP_STOP1       4'h1
`define SMP_STOP2       4'h2
`define SMP_IDX_MP8     4'h8
`define SMP_IDX_MP7     4'h7
`define SMP_FILT_RST    3'h7

`endif

// File: inc/smp_pkg.sv
// Types of the multiprocessor serial unit: states and register images.
// Assumes the constants of smp_defs.svh.
`include "smp_defs.svh"
package smp_pkg;

   typedef enum logic [1:0] {SMP_T_IDLE, SMP_T_ASYNC, SMP_T_SYNC} smp_tx_st_t;
   typedef enum logic [1:0] {SMP_R_IDLE, SMP_R_START, SMP_R_BITS, SMP_R_STOP} smp_rx_st_t;

   typedef struct packed {
      logic [`SMP_CTRL_W-1:0] ctrl;
      logic [15:0]            baud;
      logic [15:0]            bcnt;
      logic [8:0]             tx_data;
      logic                   tx_empty;
      smp_tx_st_t             tx_st;
      logic [11:0]            tx_sh;
      logic [3:0]             tx_left;
      logic [3:0]             tx_tick;
      logic                   txd;
      logic                   sck;
      logic                   sck_prev;
      logic [2:0]             half;
      logic [3:0]             sbit;
      smp_rx_st_t             rx_st;
      logic [3:0]             rx_tick;
      logic [3:0]             rx_idx;
      logic [8:0]             rx_sh;
      logic [7:0]             rx_data;
      logic                   rx_mpb;
      logic                   rx_full;
      logic                   ovr;
      logic                   framing_error_flag;
      logic                   rx_evt;
      logic [31:0]            prdata;
      logic                   pslverr;
   } smp_state_t;

   typedef struct packed {
      logic [2:0] stage;
      logic       level;
   } smp_filt_t;

endpackage

// File: src/smp_rx_filter.sv
// Three-stage all-match noise filter for the receive line.
// Assumes sample_en_i pulses once per sixteenth of a bit.
`timescale 1ns/1ps
`include "smp_defs.svh"
module smp_rx_filter (
   input  wire logic mclk_i,       // System clock
   input  wire logic rst_i,        // Asynchronous reset, active high
   input  wire logic sample_en_i,  // Sixteen-times bit rate sample pulse
   input  wire logic rx_i,         // Raw receive level
   output logic      rx_o          // Filtered receive level
);

   smp_pkg::smp_filt_t f_q;
   smp_pkg::smp_filt_t f_d;

   // Shift samples, pass a level on only when all three stages agree
   always_comb begin
      f_d = f_q;
      if (sample_en_i) begin
         f_d.stage = {f_q.stage[1:0], rx_i};
         if (&f_q.stage) begin
            f_d.level = 1'b1;
         end else if (~|f_q.stage) begin
            f_d.level = 1'b0;
         end
      end
   end

   // State register
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         f_q.stage <= `SMP_FILT_RST;
         f_q.level <= 1'b1;
      end else begin
         f_q <= f_d;
      end
   end

   assign rx_o = f_q.level;

   // Disagreeing stages hold the previous level
   filt_hold_a: assert property (@(posedge mclk_i) disable iff (rst_i)
      (sample_en_i && !(&f_q.stage) && (|f_q.stage)) |=> $stable(rx_o))
      else $error("filter level changed without three matching samples");

endmodule

// File: src/smp_serial_unit.sv
// Multiprocessor serial unit: async frames with an ID/data bit, clocked
// synchronous mode, receive noise filter, APB register slave.
// Assumes an APB master on mclk_i; serial pins are synchronous to mclk_i.
`timescale 1ns/1ps
`include "smp_defs.svh"
module smp_serial_unit (
   input  wire logic        mclk_i,              // 10 MHz system clock
   input  wire logic        rst_i,               // Asynchronous reset, active high
   input  wire logic        psel_i,              // APB select
   input  wire logic        penable_i,           // APB enable
   input  wire logic        pwrite_i,            // APB direction
   input  wire logic [11:0] paddr_i,             // APB byte address
   input  wire logic [31:0] pwdata_i,            // APB write data
   output logic      [31:0] prdata_o,            // APB read data
   output logic             pready_o,            // APB ready
   output logic             pslverr_o,           // APB error, unmapped address
   input  wire logic        serial_rx_pin_i,     // Receive line
   output logic             serial_tx_pin_o,     // Transmit line
   input  wire logic        serial_clock_pin_i,  // Shift clock pin input
   output logic             serial_clock_pin_o,  // Shift clock pin output
   output logic             serial_clock_pin_oe_o, // Shift clock pin drive enable
   output logic             request_to_send_pin_n_o, // Request to send, active low
   output logic             rx_complete_o        // Reception complete request pulse
);

   smp_pkg::smp_state_t s_q;
   smp_pkg::smp_state_t s_d;

   logic       tick;
   logic       filt_level;
   logic       rxd;
   logic       mp_mode;
   logic       sync_mode;
   logic       len8;
   logic       idle_lvl;
   logic       ext_ck;
   logic       sck_in;
   logic       drive_e;
   logic       sample_e;
   logic       setup;
   logic       wr;
   logic       rd;
   logic       wr_ctrl;
   logic       fin;
   logic       fin_mpb;
   logic [7:0] fin_dat;
   logic [7:0] sync_byte;
   logic [11:0] frame;
   logic [31:0] rdat;

   ////////////////////////////////////////////////////////////////////////
   // Decode of mode, clock edges and bus phases
   assign mp_mode   = (s_q.ctrl[`SMP_CTRL_MODE] == `SMP_MODE_MP7) ||
                      (s_q.ctrl[`SMP_CTRL_MODE] == `SMP_MODE_MP8);
   assign len8      = (s_q.ctrl[`SMP_CTRL_MODE] == `SMP_MODE_MP8);
   assign sync_mode = (s_q.ctrl[`SMP_CTRL_MODE] == `SMP_MODE_SYNC);
   assign tick      = (s_q.bcnt == s_q.baud);
   assign idle_lvl  = ~s_q.ctrl[`SMP_CTRL_POL];
   assign ext_ck    = s_q.ctrl[`SMP_CTRL_EXTCK];
   assign sck_in    = ext_ck ? serial_clock_pin_i : s_q.sck;
   // Leaving idle level drives data, returning to it samples
   assign drive_e   = (s_q.tx_st == smp_pkg::SMP_T_SYNC) &&
                      (s_q.sck_prev == idle_lvl) && (sck_in != idle_lvl);
   assign sample_e  = (s_q.tx_st == smp_pkg::SMP_T_SYNC) &&
                      (s_q.sck_prev != idle_lvl) && (sck_in == idle_lvl);
   assign setup     = psel_i && !penable_i;
   assign wr        = psel_i && penable_i && pwrite_i;
   assign rd        = psel_i && penable_i && !pwrite_i;
   assign wr_ctrl   = wr && (paddr_i == `SMP_OFF_CTRL);
   // Filtered or raw receive level for async frames
   assign rxd       = s_q.ctrl[`SMP_CTRL_FILT] ? filt_level : serial_rx_pin_i;
   assign fin       = (s_q.rx_st == smp_pkg::SMP_R_STOP) && tick &&
                      (s_q.rx_tick == `SMP_TICK_LAST);
   assign fin_mpb   = len8 ? s_q.rx_sh[`SMP_IDX_MP8] : s_q.rx_sh[`SMP_IDX_MP7];
   assign fin_dat   = len8 ? s_q.rx_sh[7:0] : {1'b0, s_q.rx_sh[6:0]};
   assign sync_byte = {serial_rx_pin_i, s_q.rx_sh[7:1]};
   // Start, data LSB first, ID bit, stop bits; no parity slot
   assign frame     = len8 ? {2'b11, s_q.tx_data[`SMP_BUF_MP], s_q.tx_data[7:0], 1'b0}
                           : {3'b111, s_q.tx_data[`SMP_BUF_MP], s_q.tx_data[6:0], 1'b0};

   ////////////////////////////////////////////////////////////////////////
   // Receive noise filter, sampled on the sixteen-times tick
   smp_rx_filter u_filter (
      .mclk_i      (mclk_i),
      .rst_i       (rst_i),
      .sample_en_i (tick),
      .rx_i        (serial_rx_pin_i),
      .rx_o        (filt_level)
   );

   ////////////////////////////////////////////////////////////////////////
   // Read data mux for the setup phase
   always_comb begin
      rdat = 32'h0000_0000;
      case (paddr_i)
         `SMP_OFF_CTRL:   rdat[`SMP_CTRL_W-1:0] = s_q.ctrl;
         `SMP_OFF_BAUD:   rdat[15:0] = s_q.baud;
         `SMP_OFF_TXBUF:  rdat[8:0] = s_q.tx_data;
         `SMP_OFF_RXBUF: begin
            rdat[7:0]         = s_q.rx_data;
            rdat[`SMP_BUF_MP] = s_q.rx_mpb;
            rdat[`SMP_RX_OVR] = s_q.ovr;
            rdat[`SMP_RX_FER] = s_q.framing_error_flag;
            rdat[`SMP_RX_SUM] = s_q.ovr | s_q.framing_error_flag;
         end
         `SMP_OFF_STATUS: begin
            rdat[`SMP_ST_TXEMPTY] = s_q.tx_empty;
            rdat[`SMP_ST_TXIDLE]  = (s_q.tx_st == smp_pkg::SMP_T_IDLE);
            rdat[`SMP_ST_RXFULL]  = s_q.rx_full;
            rdat[`SMP_ST_OVR]     = s_q.ovr;
            rdat[`SMP_ST_FER]     = s_q.framing_error_flag;
            rdat[`SMP_ST_SUM]     = s_q.ovr | s_q.framing_error_flag;
         end
         default: rdat = 32'h0000_0000;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Next state of the whole unit
   always_comb begin
      s_d        = s_q;
      s_d.rx_evt = 1'b0;
      s_d.bcnt   = tick ? 16'h0000 : s_q.bcnt + 16'h0001;
      s_d.sck_prev = sck_in;
      // Bus: answer captured in setup, clears before hardware sets
      if (setup) begin
         s_d.prdata  = rdat;
         s_d.pslverr = (paddr_i != `SMP_OFF_CTRL) && (paddr_i != `SMP_OFF_BAUD) &&
                       (paddr_i != `SMP_OFF_TXBUF) && (paddr_i != `SMP_OFF_RXBUF) &&
                       (paddr_i != `SMP_OFF_STATUS);
      end
      if (rd && (paddr_i == `SMP_OFF_RXBUF)) begin
         s_d.rx_full = 1'b0;
      end
      if (wr && (paddr_i == `SMP_OFF_STATUS)) begin
         if (pwdata_i[`SMP_ST_RXFULL]) s_d.rx_full = 1'b0;
         if (pwdata_i[`SMP_ST_OVR])    s_d.ovr = 1'b0;
         if (pwdata_i[`SMP_ST_FER])    s_d.framing_error_flag = 1'b0;
      end
      if (s_q.tx_st != smp_pkg::SMP_T_SYNC) begin
         s_d.sck = idle_lvl;
      end
      // Transmitter and synchronous shifter
      case (s_q.tx_st)
         smp_pkg::SMP_T_IDLE: begin
            s_d.txd = 1'b1;
            if (s_q.ctrl[`SMP_CTRL_TXEN] && !s_q.tx_empty && mp_mode) begin
               s_d.txd      = frame[0];
               s_d.tx_sh    = {1'b1, frame[11:1]};
               s_d.tx_left  = (len8 ? `SMP_LEFT_MP8 : `SMP_LEFT_MP7) +
                              (s_q.ctrl[`SMP_CTRL_STP2] ? `SMP_STOP2 : `SMP_STOP1);
               s_d.tx_tick  = 4'h0;
               s_d.tx_empty = 1'b1;
               s_d.tx_st    = smp_pkg::SMP_T_ASYNC;
            end else if (s_q.ctrl[`SMP_CTRL_TXEN] && !s_q.tx_empty && sync_mode &&
                         (!ext_ck || (sck_in == idle_lvl))) begin
               s_d.tx_sh    = {4'hF, s_q.tx_data[7:0]};
               s_d.tx_empty = 1'b1;
               s_d.sbit     = 4'h0;
               s_d.half     = 3'h0;
               s_d.tx_st    = smp_pkg::SMP_T_SYNC;
            end
         end
         smp_pkg::SMP_T_ASYNC: begin
            if (tick) begin
               s_d.tx_tick = s_q.tx_tick + 4'h1;
               if (s_q.tx_tick == `SMP_TICK_LAST) begin
                  if (s_q.tx_left == 4'h0) begin
                     s_d.tx_st = smp_pkg::SMP_T_IDLE;
                  end else begin
                     s_d.txd     = s_q.tx_sh[0];
                     s_d.tx_sh   = {1'b1, s_q.tx_sh[11:1]};
                     s_d.tx_left = s_q.tx_left - 4'h1;
                  end
               end
            end
         end
         smp_pkg::SMP_T_SYNC: begin
            // Only the active transmitter makes the shift clock
            if (!ext_ck && tick) begin
               s_d.half = s_q.half + 3'h1;
               if (s_q.half == `SMP_HALF_LAST) begin
                  s_d.sck = ~s_q.sck;
               end
            end
            if (drive_e) begin
               s_d.txd   = s_q.tx_sh[0];
               s_d.tx_sh = {1'b1, s_q.tx_sh[11:1]};
            end
            if (sample_e) begin
               s_d.rx_sh[7:0] = sync_byte;
               s_d.sbit       = s_q.sbit + 4'h1;
               if (s_q.sbit == `SMP_SYNC_LAST) begin
                  s_d.tx_st = smp_pkg::SMP_T_IDLE;
                  if (s_q.ctrl[`SMP_CTRL_RXEN]) begin
                     if (s_d.rx_full || s_q.rx_full) begin
                        s_d.ovr = 1'b1;
                     end else begin
                        s_d.rx_data = sync_byte;
                        s_d.rx_mpb  = 1'b0;
                        s_d.rx_full = 1'b1;
                        s_d.rx_evt  = 1'b1;
                     end
                  end
               end
            end
         end
         default: s_d.tx_st = smp_pkg::SMP_T_IDLE;
      endcase
      // Asynchronous multiprocessor receiver
      if (!mp_mode || !s_q.ctrl[`SMP_CTRL_RXEN]) begin
         s_d.rx_st = smp_pkg::SMP_R_IDLE;
      end else if (tick) begin
         s_d.rx_tick = s_q.rx_tick + 4'h1;
         case (s_q.rx_st)
            smp_pkg::SMP_R_IDLE: begin
               s_d.rx_tick = 4'h0;
               if (!rxd) s_d.rx_st = smp_pkg::SMP_R_START;
            end
            smp_pkg::SMP_R_START: begin
               if (s_q.rx_tick == `SMP_TICK_MID) begin
                  s_d.rx_tick = 4'h0;
                  s_d.rx_idx  = 4'h0;
                  s_d.rx_st   = rxd ? smp_pkg::SMP_R_IDLE : smp_pkg::SMP_R_BITS;
               end
            end
            smp_pkg::SMP_R_BITS: begin
               if (s_q.rx_tick == `SMP_TICK_LAST) begin
                  s_d.rx_sh[s_q.rx_idx] = rxd;
                  s_d.rx_idx = s_q.rx_idx + 4'h1;
                  if (s_q.rx_idx == (len8 ? `SMP_IDX_MP8 : `SMP_IDX_MP7)) begin
                     s_d.rx_st = smp_pkg::SMP_R_STOP;
                  end
               end
            end
            smp_pkg::SMP_R_STOP: begin
               if (fin) begin
                  s_d.rx_st = smp_pkg::SMP_R_IDLE;
                  // Skip data frames while waiting for an ID frame
                  if (!s_q.ctrl[`SMP_CTRL_MP_RECEIVE_ENABLE] || fin_mpb) begin
                     if (s_q.rx_full) begin
                        s_d.ovr = 1'b1;
                     end else begin
                        s_d.rx_data = fin_dat;
                        s_d.rx_mpb  = fin_mpb;
                        s_d.rx_full = 1'b1;
                        s_d.rx_evt  = 1'b1;
                        if (!rxd) s_d.framing_error_flag = 1'b1;
                     end
                     if (fin_mpb) s_d.ctrl[`SMP_CTRL_MP_RECEIVE_ENABLE] = 1'b0;
                  end
               end
            end
            default: s_d.rx_st = smp_pkg::SMP_R_IDLE;
         endcase
      end
      // Software writes of control, divider and transmit buffer
      if (wr_ctrl) begin
         s_d.ctrl = pwdata_i[`SMP_CTRL_W-1:0];
      end
      if (wr && (paddr_i == `SMP_OFF_BAUD)) begin
         s_d.baud = pwdata_i[15:0];
         s_d.bcnt = 16'h0000;
      end
      if (wr && (paddr_i == `SMP_OFF_TXBUF)) begin
         s_d.tx_data  = pwdata_i[8:0];
         s_d.tx_empty = 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // State register
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         s_q          <= '0;
         s_q.ctrl     <= `SMP_CTRL_RST;
         s_q.baud     <= `SMP_BAUD_RST;
         s_q.tx_empty <= 1'b1;
         s_q.txd      <= 1'b1;
         s_q.sck      <= 1'b1;
         s_q.sck_prev <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Outputs
   assign prdata_o              = s_q.prdata;
   assign pready_o              = 1'b1;
   assign pslverr_o             = s_q.pslverr;
   assign serial_tx_pin_o       = s_q.txd;
   assign serial_clock_pin_o    = s_q.sck;
   assign serial_clock_pin_oe_o = sync_mode && !ext_ck;
   assign rx_complete_o         = s_q.rx_evt;
   // Request low while ready, only with external clock
   assign request_to_send_pin_n_o = !(sync_mode && ext_ck && s_q.ctrl[`SMP_CTRL_RTSEN] &&
                                      s_q.ctrl[`SMP_CTRL_RXEN] &&
                                      (s_q.tx_st != smp_pkg::SMP_T_SYNC));

   ////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (rst_i);

   sequence rx_fin_skip_s;
      fin && s_q.ctrl[`SMP_CTRL_MP_RECEIVE_ENABLE] && !fin_mpb;
   endsequence
   sequence rx_fin_id_s;
      fin && s_q.ctrl[`SMP_CTRL_MP_RECEIVE_ENABLE] && fin_mpb && !s_q.rx_full && !wr_ctrl;
   endsequence
   sequence tx_load_s;
      (s_q.tx_st == smp_pkg::SMP_T_IDLE) ##1 (s_q.tx_st == smp_pkg::SMP_T_ASYNC);
   endsequence

   mp_skip_frame_a: assert property (rx_fin_skip_s |=> !s_q.rx_evt &&
                                     $stable(s_q.rx_data) && $stable(s_q.framing_error_flag))
      else $error("data frame accepted while waiting for ID");
   mp_id_accept_a: assert property (rx_fin_id_s |=> s_q.rx_evt && s_q.rx_mpb &&
                                    !s_q.ctrl[`SMP_CTRL_MP_RECEIVE_ENABLE] && s_q.rx_full)
      else $error("ID frame did not resume reception");
   id_event_a: assert property (rx_fin_id_s |=> rx_complete_o ##1 !rx_complete_o)
      else $error("ID frame event missing or not a pulse");
   tx_mp_bit_a: assert property (tx_load_s |-> (len8 ? s_q.tx_sh[`SMP_IDX_MP8] :
                                 s_q.tx_sh[`SMP_IDX_MP7]) == $past(s_q.tx_data[`SMP_BUF_MP], 1))
      else $error("sent ID bit differs from written bit");
   frame_len_a: assert property (tx_load_s |-> s_q.tx_left ==
                                 ((len8 ? `SMP_LEFT_MP8 : `SMP_LEFT_MP7) +
                                 (s_q.ctrl[`SMP_CTRL_STP2] ? `SMP_STOP2 : `SMP_STOP1)))
      else $error("frame length wrong for mode and stop bits");
   rts_busy_a: assert property ((s_q.tx_st == smp_pkg::SMP_T_SYNC) ||
                                !ext_ck |-> request_to_send_pin_n_o)
      else $error("request to send low while receiving or internal clock");
   drive_edge_a: assert property (drive_e |=> serial_tx_pin_o == $past(s_q.tx_sh[0]))
      else $error("transmit bit not driven on the drive edge");
   sync_start_a: assert property ((s_q.tx_st == smp_pkg::SMP_T_IDLE) && sync_mode &&
                                  !ext_ck && s_q.ctrl[`SMP_CTRL_TXEN] && !s_q.tx_empty
                                  |=> s_q.tx_st == smp_pkg::SMP_T_SYNC)
      else $error("internal shift clock did not start");
   sync_overrun_a: assert property (sample_e && (s_q.sbit == `SMP_SYNC_LAST) &&
                                    s_q.ctrl[`SMP_CTRL_RXEN] && s_q.rx_full
                                    |=> s_q.ovr && !rx_complete_o)
      else $error("synchronous overrun not flagged or raised an event");

endmodule

// File: verification/smp_peer.sv
// Far-side station model: sends multiprocessor frames on the receive line
// and exchanges clocked bytes, making or following the shift clock.
// Assumes a 16-clock bit time and an 8-clock half shift clock (baud zero).
`timescale 1ns/1ps
module smp_peer (
   input  wire logic mclk_i, // System clock
   input  wire logic sck_i,  // Shift clock made by the unit
   input  wire logic txd_i,  // Transmit line of the unit
   output logic      line_o, // Line into the unit, idle high
   output logic      sck_o   // Shift clock made here, idle high
);
   // Line rests high between frames
   initial line_o = 1'b1;
   // Clock rests at idle until a clocked byte is exchanged
   initial sck_o = 1'b1;
   // Start low, data LSB first, ID bit, one high stop
   task automatic send(input logic [8:0] v);
      logic [10:0] f;
      f = {1'b1, v, 1'b0};
      for (int i = 0; i < 11; i++) begin
         @(posedge mclk_i);
         line_o <= f[i];
         repeat (15) @(posedge mclk_i);
      end
   endtask
   // Clocked byte, LSB first: data changes as the clock leaves idle and the
   // unit's bit is taken as it returns; ok falls if the unit's clock stalls
   task automatic xfer(input logic ext, input logic idle, input logic [7:0] v,
                       output logic [7:0] got, output logic ok);
      int k;
      got = 8'h00;
      ok  = 1'b1;
      for (int i = 0; i < 8; i++) begin
         if (ext) begin
            @(posedge mclk_i);
            sck_o  <= ~idle;
            line_o <= v[i];
            repeat (8) @(posedge mclk_i);
            got[i] = txd_i;
            sck_o  <= idle;
            repeat (8) @(posedge mclk_i);
         end else begin
            k = 0;
            while (sck_i === idle && k < 64) begin @(posedge mclk_i); k++; end
            line_o <= v[i];
            while (sck_i !== idle && k < 64) begin @(posedge mclk_i); k++; end
            got[i] = txd_i;
            if (k >= 64) ok = 1'b0;
         end
      end
      line_o <= 1'b1;
   endtask
endmodule

// File: verification/tb.sv
// Bench for the serial unit: APB tasks, frame capture, ID filtering.
// Assumes smp_peer drives the receive line and makes or follows the shift clock.
`timescale 1ns/1ps
`include "smp_defs.svh"
module tb;
   logic        mclk_i = 1'b0, rst_i = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [11:0] paddr  = 12'h000;
   logic [31:0] pwdata = 32'h00000000, prdata, r;
   logic        pready, pslverr, ev, rxl, txl, rxc;
   int          n_errors = 0, n_compared = 0, n_rx = 0;
   logic [7:0]  g8;
   logic        ok, ck, eck, oe, rts_n;
   int          n_rts = 0, n_hi = 0;
   // Clock and parts
   initial forever #50 mclk_i = ~mclk_i;
   smp_peer peer (.mclk_i(mclk_i), .sck_i(ck), .txd_i(txl), .line_o(rxl), .sck_o(eck));
   smp_serial_unit DUT (.mclk_i(mclk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .serial_rx_pin_i(rxl), .serial_tx_pin_o(txl),
      .serial_clock_pin_i(eck), .serial_clock_pin_o(ck), .serial_clock_pin_oe_o(oe),
      .request_to_send_pin_n_o(rts_n), .rx_complete_o(rxc));
   // Count completion pulses and cycles with request to send high
   always @(posedge mclk_i) if (rxc === 1'b1) n_rx++;
   always @(posedge mclk_i) if (rts_n === 1'b1) n_rts++;
   ////////////////////////////////////////////////////////////////////////////////
   task conclude;
      $display("Counts: %0d compared, %0d mismatches", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         n_errors++;
         $display("Error at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // One APB transfer; result lands in r and ev
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int k;
      @(posedge mclk_i);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge mclk_i);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge mclk_i); k++; end while (pready !== 1'b1 && k < 20);
      if (pready !== 1'b1) begin n_errors++; conclude; end
      r = prdata;
      ev = pslverr;
      psel <= 1'b0; penable <= 1'b0;
   endtask
   // Send one byte and sample the line mid-bit
   task txf(input logic [31:0] c, input logic [8:0] v, input logic [10:0] e);
      logic [10:0] g;
      int          k;
      apb(1'b1, `SMP_OFF_CTRL, c);
      apb(1'b1, `SMP_OFF_TXBUF, {23'h000000, v});
      k = 0;
      while (txl !== 1'b0 && k < 50) begin @(posedge mclk_i); k++; end
      if (txl !== 1'b0) begin n_errors++; conclude; end
      repeat (8) @(posedge mclk_i);
      for (int i = 0; i < 11; i++) begin g[i] = txl; repeat (16) @(posedge mclk_i); end
      chk({21'h000000, g}, {21'h000000, e});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      repeat (6) @(posedge mclk_i);
      rst_i <= 1'b0;
      apb(1'b0, `SMP_OFF_CTRL, 32'h00000000);
      chk(r, 32'h00000000);
      apb(1'b0, `SMP_OFF_BAUD, 32'h00000000);
      chk(r, 32'h00000040);
      apb(1'b0, `SMP_OFF_STATUS, 32'h00000000);
      chk(r & 32'h00000001, 32'h00000001);
      apb(1'b0, 12'h020, 32'h00000000);
      chk({31'h00000000, ev}, 32'h00000001);
      chk(r, 32'h00000000);
      $display("Test reset and map done");
      apb(1'b1, `SMP_OFF_BAUD, 32'h00000000);
      txf(32'h00000025, 9'h1A5, 11'h74A);
      txf(32'h00000024, 9'h055, 11'h6AA);
      $display("Test transmit done");
      apb(1'b1, `SMP_OFF_CTRL, 32'h00000445);
      peer.send(9'h033);
      repeat (20) @(posedge mclk_i);
      chk(32'(n_rx), 32'h00000000);
      apb(1'b0, `SMP_OFF_STATUS, 32'h00000000);
      chk(r & 32'h0000001C, 32'h00000000);
      peer.send(9'h15A);
      repeat (20) @(posedge mclk_i);
      chk(32'(n_rx), 32'h00000001);
      apb(1'b0, `SMP_OFF_RXBUF, 32'h00000000);
      chk(r, 32'h0000015A);
      apb(1'b0, `SMP_OFF_CTRL, 32'h00000000);
      chk(r, 32'h00000045);
      $display("Test receive done");
      apb(1'b1, `SMP_OFF_CTRL, 32'h0000004D);
      peer.send(9'h0C3);
      repeat (20) @(posedge mclk_i);
      apb(1'b0, `SMP_OFF_RXBUF, 32'h00000000);
      chk(r, 32'h000000C3);
      $display("Test filter done");
      apb(1'b1, `SMP_OFF_CTRL, 32'h00000171);
      repeat (2) @(posedge mclk_i);
      chk({29'h00000000, ck, oe, rts_n}, 32'h00000003);
      apb(1'b1, `SMP_OFF_TXBUF, 32'h000000C3);
      peer.xfer(1'b0, 1'b0, 8'h96, g8, ok);
      chk({23'h000000, ok, g8}, 32'h000001C3);
      apb(1'b0, `SMP_OFF_RXBUF, 32'h00000000);
      chk(r, 32'h00000096);
      apb(1'b1, `SMP_OFF_CTRL, 32'h000001E1);
      repeat (2) @(posedge mclk_i);
      chk({29'h00000000, ck, oe, rts_n}, 32'h00000004);
      n_hi = n_rts;
      apb(1'b1, `SMP_OFF_TXBUF, 32'h0000005A);
      peer.xfer(1'b1, 1'b1, 8'h3C, g8, ok);
      chk({23'h000000, ok, g8}, 32'h0000015A);
      chk({30'h00000000, n_rts != n_hi, rts_n}, 32'h00000002);
      apb(1'b1, `SMP_OFF_TXBUF, 32'h000000A6);
      peer.xfer(1'b1, 1'b1, 8'hE7, g8, ok);
      chk({23'h000000, ok, g8}, 32'h000001A6);
      apb(1'b0, `SMP_OFF_STATUS, 32'h00000000);
      chk(r, 32'h0000002F);
      chk(32'(n_rx), 32'h00000004);
      $display("Test clocked mode done");
      conclude;
   end
endmodule
